// *** pkg/pds_pkg.sv ***
// Purpose: constants and types shared by the dispense sequencer
// Assumes: 10 MHz clock, Avalon-MM word addressing
// Notes: step memory holds 10 programs of 23 steps
package pds_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int REQ_DET_MS = 20;
  // filter half the detect time so a held level is seen well inside it
  localparam int REQ_STABLE_CYC = (REQ_DET_MS * MS_CYC) / 2;
  localparam int RUN_LAG_MS = 100;
  localparam int RUN_LAG_CYC = RUN_LAG_MS * MS_CYC;

  localparam int NUM_PROG = 10;
  localparam int NUM_STEP = 23;
  localparam int NUM_FIELD = 5;
  localparam int MEM_DEPTH = NUM_PROG * NUM_STEP;
  localparam logic [4:0] LAST_STEP = 5'h16;
  localparam logic [7:0] STEP_STRIDE = 8'h17;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_PROG = 4'h2;
  localparam logic [3:0] REG_DOT_SIZE = 4'h3;
  localparam logic [3:0] REG_SPEED = 4'h4;
  localparam logic [3:0] REG_RAMP = 4'h5;
  localparam logic [3:0] REG_BF_CNT = 4'h6;
  localparam logic [3:0] REG_FLASH = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_LINE_CNT = 4'h9;
  localparam logic [3:0] REG_MEM_SEL = 4'hA;
  localparam logic [3:0] REG_MEM_W0 = 4'hB;
  localparam logic [3:0] REG_MEM_W1 = 4'hC;
  localparam logic [3:0] REG_MEM_W2 = 4'hD;

  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PROG = 1;
  localparam int CTRL_INV = 2;
  localparam int CTRL_BF = 3;
  localparam int CTRL_LINE = 4;
  localparam int CTRL_PUMP = 5;
  localparam int CMD_RESET = 0;
  localparam int CMD_SKIP_OBJ = 1;
  localparam int CMD_SKIP_STEP = 2;

  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic is_line;
    logic [23:0] size;
    logic [11:0] speed;
    logic [19:0] ramp_ms;
    logic [9:0] count;
  } pds_step_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FWD, ST_BACK, ST_DONE} pds_state_t;
endpackage : pds_pkg

// *** src/pds_sequencer.sv ***
// Purpose: dispense pump sequencer with Avalon-MM register access
// Assumes: amplifier runs each move and pulses move_done after decel
// Notes: one clock, synchronous active-high reset
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pds_sequencer import pds_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC,
  parameter int REQ_STABLE = REQ_STABLE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic pump_req_in,
  input wire logic motor_moving,
  input wire logic move_done,
  input wire logic motor_count,
  output logic move_go,
  output logic move_rev,
  output logic move_line,
  output logic [24:0] move_size,
  output logic [11:0] move_speed,
  output logic [19:0] move_ramp_ms,
  output logic pump_run_n,
  output logic prog_done
);

  typedef struct packed {
    pds_state_t state;
    logic wreq;
    logic [31:0] rdata;
    logic [5:0] ctrl;
    logic [3:0] prog;
    logic [3:0] prev_prog;
    logic [23:0] dsize;
    logic [11:0] speed;
    logic [19:0] ramp;
    logic [23:0] bf_cnt;
    logic [15:0] flash_ms;
    logic [3:0] msel_prog;
    logic [4:0] msel_step;
    logic [4:0] step;
    logic [9:0] obj;
    logic [23:0] line_cnt;
    logic req_s1;
    logic req_s2;
    logic req_f;
    logic [17:0] filt;
    logic start_prev;
    logic mv_go;
    logic mv_rev;
    logic mv_line;
    logic [24:0] mv_size;
    logic [11:0] mv_speed;
    logic [19:0] mv_ramp;
    logic bf_owed;
    logic done_pend;
    logic done;
    logic [15:0] flash_cnt;
    logic [13:0] ms_cnt;
    logic run_n;
  } pds_regs_t;

  pds_regs_t s_reg;
  pds_regs_t s_next;
  pds_step_t mem [MEM_DEPTH];

  logic wr;
  logic [7:0] cur_idx;
  logic [7:0] nxt_idx;
  logic [7:0] sel_idx;
  logic sel_ok;
  pds_step_t cur;
  pds_step_t nxt;
  pds_step_t sel;
  logic [4:0] step_inc;
  logic wrap;
  logic [4:0] step_after;
  logic [9:0] obj_inc;
  logic roll;
  logic req_act;
  logic start_lvl;
  logic start_ev;
  logic cmd_wr;
  logic [31:0] rd_mux;

  assign wr = write && !s_reg.wreq;
  assign cmd_wr = wr && (address == REG_CMD);
  assign cur_idx = s_reg.prog * STEP_STRIDE + 8'(s_reg.step);
  assign step_inc = (s_reg.step == LAST_STEP) ? 5'h00 : s_reg.step + 5'h01;
  assign nxt_idx = s_reg.prog * STEP_STRIDE + 8'(step_inc);
  assign sel_idx = s_reg.msel_prog * STEP_STRIDE + 8'(s_reg.msel_step);
  assign sel_ok = (s_reg.msel_prog < 4'(NUM_PROG)) && (s_reg.msel_step <= LAST_STEP);
  assign cur = mem[cur_idx];
  assign nxt = mem[nxt_idx];
  assign sel = sel_ok ? mem[sel_idx] : '0;
  // wrap past last slot or at first zero-speed step
  assign wrap = (s_reg.step == LAST_STEP) || (nxt.speed == 12'h000);
  assign step_after = wrap ? 5'h00 : step_inc;
  assign obj_inc = s_reg.obj + 10'h001;
  // >= so a zero count cannot trap the pointer
  assign roll = (obj_inc >= cur.count);
  // idle level is high; the active level is low unless inverted
  assign req_act = s_reg.ctrl[CTRL_INV] ? s_reg.req_f : !s_reg.req_f;
  assign start_lvl = s_reg.ctrl[CTRL_AUTO] ? req_act : s_reg.ctrl[CTRL_PUMP];
  assign start_ev = start_lvl && !s_reg.start_prev;

  // step storage, no reset: software fills it before program mode
  always_ff @(posedge clock) begin
    if (wr && sel_ok) begin
      if (address == REG_MEM_W0) begin
        mem[sel_idx].is_line <= writedata[31];
        mem[sel_idx].size <= writedata[23:0];
      end else if (address == REG_MEM_W1) begin
        mem[sel_idx].speed <= writedata[11:0];
        mem[sel_idx].count <= writedata[25:16];
      end else if (address == REG_MEM_W2) begin
        mem[sel_idx].ramp_ms <= writedata[19:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (address == REG_CTRL) begin
      rd_mux = {26'h0, s_reg.ctrl};
    end else if (address == REG_PROG) begin
      rd_mux = {28'h0, s_reg.prog};
    end else if (address == REG_DOT_SIZE) begin
      rd_mux = {8'h00, s_reg.dsize};
    end else if (address == REG_SPEED) begin
      rd_mux = {20'h0, s_reg.speed};
    end else if (address == REG_RAMP) begin
      rd_mux = {12'h000, s_reg.ramp};
    end else if (address == REG_BF_CNT) begin
      rd_mux = {8'h00, s_reg.bf_cnt};
    end else if (address == REG_FLASH) begin
      rd_mux = {16'h0000, s_reg.flash_ms};
    end else if (address == REG_STATUS) begin
      rd_mux = {6'h00, s_reg.obj, 3'h0, s_reg.step, 4'h0, s_reg.bf_owed,
                s_reg.done, !s_reg.run_n, s_reg.state != ST_IDLE};
    end else if (address == REG_LINE_CNT) begin
      rd_mux = {8'h00, s_reg.line_cnt};
    end else if (address == REG_MEM_SEL) begin
      rd_mux = {20'h0, s_reg.msel_prog, 3'h0, s_reg.msel_step};
    end else if (address == REG_MEM_W0) begin
      rd_mux = {sel.is_line, 7'h00, sel.size};
    end else if (address == REG_MEM_W1) begin
      rd_mux = {6'h00, sel.count, 4'h0, sel.speed};
    end else if (address == REG_MEM_W2) begin
      rd_mux = {12'h000, sel.ramp_ms};
    end
  end

  always_comb begin
    s_next = s_reg;
    // one wait cycle, then the answer for one cycle
    s_next.wreq = !((read || write) && s_reg.wreq);
    if (read && s_reg.wreq) begin
      s_next.rdata = rd_mux;
    end
    if (wr) begin
      if (address == REG_CTRL) begin
        s_next.ctrl = writedata[5:0];
      end else if (address == REG_PROG) begin
        if (writedata[3:0] < 4'(NUM_PROG)) begin
          s_next.prog = writedata[3:0];
        end
      end else if (address == REG_DOT_SIZE) begin
        s_next.dsize = writedata[23:0];
      end else if (address == REG_SPEED) begin
        s_next.speed = writedata[11:0];
      end else if (address == REG_RAMP) begin
        s_next.ramp = writedata[19:0];
      end else if (address == REG_BF_CNT) begin
        s_next.bf_cnt = writedata[23:0];
      end else if (address == REG_FLASH) begin
        s_next.flash_ms = writedata[15:0];
      end else if (address == REG_MEM_SEL) begin
        s_next.msel_prog = writedata[11:8];
        s_next.msel_step = writedata[4:0];
      end
    end

    // the first stage feeds only the second; the filter reads the second
    s_next.req_s1 = pump_req_in;
    s_next.req_s2 = s_reg.req_s1;
    if (s_reg.req_s2 != s_reg.req_f) begin
      if (s_reg.filt == 18'(REQ_STABLE - 1)) begin
        s_next.req_f = s_reg.req_s2;
        s_next.filt = 18'h0_0000;
      end else begin
        s_next.filt = s_reg.filt + 18'h0_0001;
      end
    end else begin
      s_next.filt = 18'h0_0000;
    end
    s_next.start_prev = start_lvl;
    s_next.run_n = !motor_moving;

    // a program change lands on step one unless a move_done in program mode rolls the pointer in the same cycle
    if (s_reg.prev_prog != s_reg.prog) begin
      s_next.prev_prog = s_reg.prog;
      s_next.step = 5'h00;
      s_next.obj = 10'h000;
    end

    case (s_reg.state)
      ST_IDLE: begin
        if (start_ev) begin
          s_next.state = ST_FWD;
          s_next.mv_go = 1'b1;
          s_next.mv_rev = 1'b0;
          s_next.done_pend = 1'b0;
          s_next.bf_owed = 1'b0;
          s_next.line_cnt = 24'h00_0000;
          if (s_reg.ctrl[CTRL_PROG]) begin
            s_next.mv_line = cur.is_line;
            s_next.mv_speed = cur.speed;
            s_next.mv_ramp = cur.ramp_ms;
            s_next.mv_size = cur.is_line ? 25'h000_0000 : {1'b0, cur.size};
          end else begin
            s_next.mv_line = s_reg.ctrl[CTRL_LINE];
            s_next.mv_speed = s_reg.speed;
            s_next.mv_ramp = s_reg.ramp;
            s_next.mv_size = s_reg.ctrl[CTRL_LINE] ? 25'h000_0000
                             : {1'b0, s_reg.dsize};
          end
          if (s_reg.bf_owed) begin
            s_next.mv_size = s_next.mv_size + {1'b0, s_reg.bf_cnt};
          end
        end else if (cmd_wr && s_reg.ctrl[CTRL_PROG]) begin
          if (writedata[CMD_RESET]) begin
            s_next.step = 5'h00;
            s_next.obj = 10'h000;
          end else if (writedata[CMD_SKIP_STEP]) begin
            s_next.step = step_after;
            s_next.obj = 10'h000;
          end else if (writedata[CMD_SKIP_OBJ]) begin
            s_next.obj = roll ? 10'h000 : obj_inc;
            if (roll) begin
              s_next.step = step_after;
            end
          end
        end
      end
      ST_FWD: begin
        // start edges here are dropped, not queued
        if (s_reg.mv_line && !start_lvl) begin
          s_next.mv_go = 1'b0;
        end
        if (s_reg.mv_line && !s_reg.ctrl[CTRL_PROG] && motor_count) begin
          s_next.line_cnt = s_reg.line_cnt + 24'h00_0001;
        end
        if (move_done) begin
          s_next.mv_go = 1'b0;
          if (s_reg.ctrl[CTRL_PROG]) begin
            s_next.obj = roll ? 10'h000 : obj_inc;
            if (roll) begin
              s_next.step = step_after;
            end
            s_next.done_pend = roll && wrap;
          end
          if (s_reg.ctrl[CTRL_BF]) begin
            s_next.state = ST_BACK;
            s_next.mv_go = 1'b1;
            s_next.mv_rev = 1'b1;
            s_next.mv_line = 1'b0;
            s_next.mv_size = {1'b0, s_reg.bf_cnt};
          end else if (s_reg.ctrl[CTRL_PROG] && roll && wrap) begin
            s_next.state = ST_DONE;
            s_next.done = 1'b1;
            s_next.flash_cnt = 16'h0000;
            s_next.ms_cnt = 14'h0000;
          end else begin
            s_next.state = ST_IDLE;
          end
        end
      end
      ST_BACK: begin
        if (move_done) begin
          s_next.mv_go = 1'b0;
          s_next.mv_rev = 1'b0;
          s_next.bf_owed = 1'b1;
          if (s_reg.done_pend) begin
            s_next.state = ST_DONE;
            s_next.done = 1'b1;
            s_next.flash_cnt = 16'h0000;
            s_next.ms_cnt = 14'h0000;
          end else begin
            s_next.state = ST_IDLE;
          end
        end
      end
      ST_DONE: begin
        // the flash holds off the next start, so it costs cycle time
        if (s_reg.flash_cnt >= s_reg.flash_ms) begin
          s_next.done = 1'b0;
          s_next.done_pend = 1'b0;
          s_next.state = ST_IDLE;
        end else if (s_reg.ms_cnt == 14'(MS_CYCLES - 1)) begin
          s_next.ms_cnt = 14'h0000;
          s_next.flash_cnt = s_reg.flash_cnt + 16'h0001;
        end else begin
          s_next.ms_cnt = s_reg.ms_cnt + 14'h0001;
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.wreq <= 1'b1;
      s_reg.rdata <= RDATA_RST;
      s_reg.ctrl <= CTRL_RST;
      s_reg.req_s1 <= 1'b1;
      s_reg.req_s2 <= 1'b1;
      s_reg.req_f <= 1'b1;
      s_reg.start_prev <= 1'b1;
      s_reg.run_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata = s_reg.rdata;
  assign waitrequest = s_reg.wreq;
  assign move_go = s_reg.mv_go;
  assign move_rev = s_reg.mv_rev;
  assign move_line = s_reg.mv_line;
  assign move_size = s_reg.mv_size;
  assign move_speed = s_reg.mv_speed;
  // amplifier uses this ramp both ways; short dots peak lower
  assign move_ramp_ms = s_reg.mv_ramp;
  assign pump_run_n = s_reg.run_n;
  assign prog_done = s_reg.done;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_start_source: assert property (
    $rose(s_reg.mv_go) && !s_reg.mv_rev |->
      ($past(s_reg.ctrl[CTRL_AUTO]) ? $past(req_act) : $past(s_reg.ctrl[CTRL_PUMP])))
    else $error("move started from a disabled source");

  chk_dot_size: assert property (
    s_reg.state == ST_IDLE && start_ev && !s_reg.ctrl[CTRL_PROG]
      && !s_reg.ctrl[CTRL_LINE] && !s_reg.bf_owed
      |=> move_size == {1'b0, $past(s_reg.dsize)} && move_go)
    else $error("single dot size differs from entry");

  chk_line_release: assert property (
    s_reg.state == ST_FWD && s_reg.mv_line && !start_lvl |=> !move_go || move_rev)
    else $error("line kept moving after release");

  chk_prog_reset: assert property (
    s_reg.state == ST_IDLE && !start_ev && cmd_wr && s_reg.ctrl[CTRL_PROG]
      && writedata[CMD_RESET] |=> s_reg.step == 5'h00 && s_reg.obj == 10'h000)
    else $error("program reset did not reach step one");

  chk_prog_change: assert property (
    s_reg.prev_prog != s_reg.prog |=> s_reg.step == 5'h00 ##1 s_reg.prev_prog == s_reg.prog)
    else $error("program change kept old step");

  chk_step_wrap: assert property (
    s_reg.state == ST_FWD && move_done && s_reg.ctrl[CTRL_PROG] && roll && wrap
      && s_reg.prev_prog == s_reg.prog |=> s_reg.step == 5'h00 && s_reg.obj == 10'h000)
    else $error("pointer did not wrap to step one");

  chk_backflow: assert property (
    s_reg.state == ST_FWD && move_done && s_reg.ctrl[CTRL_BF]
      |=> move_go && move_rev && move_size == {1'b0, $past(s_reg.bf_cnt)})
    else $error("no reverse move after forward move");

  chk_run_out: assert property (
    motor_moving ##1 motor_moving |-> !pump_run_n)
    else $error("running output lags motion");

  chk_busy_ignore: assert property (
    s_reg.state != ST_IDLE |=> !($rose(move_go) && !move_rev))
    else $error("forward move started while busy");

  chk_done_short: assert property (
    s_reg.state == ST_DONE && s_reg.flash_ms == 16'h0000 |=> !prog_done)
    else $error("zero flash time not shortest");

  chk_bus_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle after wait");

endmodule : pds_sequencer

// *** testbench/pds_amp_model.sv ***
// Purpose: behavioural amplifier at the motor side of the dispense sequencer
// Assumes: one motor count per cycle while running, fixed short decel tail
// Notes: a 2-cycle hold-off after each finished move stops it re-reading the old go level
`timescale 1ns/1ps
module pds_amp_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic move_go,
  input wire logic move_line,
  input wire logic [24:0] move_size,
  output logic motor_moving = 1'b0,
  output logic move_done = 1'b0,
  output logic motor_count = 1'b0
);
  int left;
  int cool;
  int tail;
  always @(posedge clock) begin
    move_done <= 1'b0;
    motor_count <= 1'b0;
    if (rst) begin
      motor_moving <= 1'b0;
      cool <= 0;
      tail <= 0;
    end else if (cool > 0) begin
      cool <= cool - 1;
    end else if (!motor_moving) begin
      if (move_go === 1'b1) begin
        motor_moving <= 1'b1;
        left <= move_line ? 0 : int'(move_size);
      end
    end else if (tail > 0) begin
      tail <= tail - 1;
      if (tail == 1) begin
        move_done <= 1'b1;
        motor_moving <= 1'b0;
        cool <= 2;
      end
    end else if (move_line ? move_go : left > 0) begin
      motor_count <= 1'b1;
      left <= left - 1;
    end else begin
      tail <= 3;
    end
  end
endmodule : pds_amp_model

// *** testbench/pds_sequencer_tb_top.sv ***
// Purpose: self-checking bench for the dispense sequencer
// Assumes: shortened timing parameters, amplifier model on the motor side
// Notes: registers reached only through the Avalon-MM task
`timescale 1ns/1ps
module pds_sequencer_tb_top;
  import pds_pkg::*;
  localparam int RS = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic pump_req_in = 1'b1;
  logic motor_moving, move_done, motor_count, move_go, move_rev, move_line;
  logic [24:0] move_size;
  logic [11:0] move_speed;
  logic [19:0] move_ramp_ms;
  logic pump_run_n, prog_done;
  logic [31:0] rd;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_line = 0;

  always #50 clock = ~clock;

  pds_sequencer #(.MS_CYCLES(10), .REQ_STABLE(RS)) dut (.clock, .rst, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .pump_req_in, .motor_moving, .move_done,
    .motor_count, .move_go, .move_rev, .move_line, .move_size, .move_speed, .move_ramp_ms,
    .pump_run_n, .prog_done);
  pds_amp_model amp (.clock, .rst, .move_go, .move_line, .move_size, .motor_moving,
    .move_done, .motor_count);

  // every count of a line move, including the one already under way at release
  always @(posedge clock) if (move_line === 1'b1 && motor_count === 1'b1)
    n_line <= n_line + 1;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // a hang is left to the watchdog; the slave owes one wait cycle, then the answer
    chk("bus latency", 32'h2, 32'(n));
  endtask : bus

  function automatic logic sig(input int k);
    case (k)
      0: return move_go;
      1: return move_rev;
      default: return prog_done;
    endcase
  endfunction : sig

  task automatic wait_sig(input string what, input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(what, 32'(v), 32'(sig(k)));
  endtask : wait_sig

  task automatic pump_dot(input logic [31:0] ctrl, input logic [24:0] size);
    bus(1, REG_CTRL, ctrl | 32'h20);
    wait_sig("go rise", 0, 1'b1, 20);
    chk("dot size", 32'(size), 32'(move_size));
    bus(1, REG_CTRL, ctrl);
    wait_sig("go fall", 0, 1'b0, 300);
    repeat (3) @(posedge clock);
  endtask : pump_dot

  task automatic step_wr(input logic [4:0] s, input logic [23:0] sz, input logic [11:0] sp,
    input logic [9:0] cnt);
    bus(1, REG_MEM_SEL, {27'h0, s});
    bus(1, REG_MEM_W0, {8'h00, sz});
    bus(1, REG_MEM_W1, {6'h00, cnt, 4'h0, sp});
    bus(1, REG_MEM_W2, 32'h2);
  endtask : step_wr

  task automatic chk_pos(input logic [4:0] s, input logic [9:0] c);
    bus(0, REG_STATUS, 32'h0);
    chk("step", 32'(s), 32'(rd[12:8]));
    chk("object counter", 32'(c), 32'(rd[25:16]));
  endtask : chk_pos

  task automatic t_manual();
    chk("run_n idle", 32'h1, 32'(pump_run_n));
    chk("done idle", 32'h0, 32'(prog_done));
    bus(0, 4'hF, 32'h0);
    chk("unmapped", RDATA_RST, rd);
    bus(1, REG_DOT_SIZE, 32'h5);
    bus(1, REG_SPEED, 32'h64);
    bus(1, REG_RAMP, 32'h3);
    pump_req_in <= 1'b0;
    repeat (12) @(posedge clock);
    chk("pin in manual", 32'h0, 32'(move_go));
    pump_req_in <= 1'b1;
    bus(1, REG_CTRL, 32'h20);
    wait_sig("go", 0, 1'b1, 20);
    chk("size", 32'h5, 32'(move_size));
    chk("speed", 32'h64, 32'(move_speed));
    chk("ramp", 32'h3, 32'(move_ramp_ms));
    repeat (3) @(posedge clock);
    chk("running", 32'h0, 32'(pump_run_n));
    bus(1, REG_CTRL, 32'h0);
    wait_sig("go fall", 0, 1'b0, 100);
    repeat (3) @(posedge clock);
    chk("stopped", 32'h1, 32'(pump_run_n));
  endtask : t_manual

  task automatic t_line();
    n_line = 0;
    bus(1, REG_CTRL, 32'h30);
    wait_sig("line go", 0, 1'b1, 20);
    chk("line flag", 32'h1, 32'(move_line));
    chk("line size", 32'h0, 32'(move_size));
    repeat (15) @(posedge clock);
    chk("line held", 32'h1, 32'(move_go));
    bus(1, REG_CTRL, 32'h10);
    wait_sig("line stop", 0, 1'b0, 4);
    repeat (10) @(posedge clock);
    bus(0, REG_LINE_CNT, 32'h0);
    chk("line count", 32'(n_line), rd);
  endtask : t_line

  task automatic t_auto();
    bus(1, REG_DOT_SIZE, 32'h28);
    bus(1, REG_CTRL, 32'h21);
    repeat (10) @(posedge clock);
    chk("panel in auto", 32'h0, 32'(move_go));
    bus(1, REG_CTRL, 32'h01);
    pump_req_in <= 1'b0;
    wait_sig("req start", 0, 1'b1, RS + 6);
    repeat (2 * RS + 2) @(posedge clock);
    pump_req_in <= 1'b1;
    repeat (2 * RS + 2) @(posedge clock);
    pump_req_in <= 1'b0;
    wait_sig("auto end", 0, 1'b0, 200);
    repeat (20) @(posedge clock);
    chk("no restart", 32'h0, 32'(move_go));
    bus(1, REG_CTRL, 32'h05);
    repeat (2 * RS + 2) @(posedge clock);
    pump_req_in <= 1'b1;
    wait_sig("inverted start", 0, 1'b1, RS + 6);
    wait_sig("inverted end", 0, 1'b0, 200);
    bus(1, REG_CTRL, 32'h0);
  endtask : t_auto

  task automatic t_program();
    step_wr(5'h00, 24'h3, 12'h1, 10'h2);
    step_wr(5'h01, 24'h6, 12'h2, 10'h1);
    step_wr(5'h02, 24'h0, 12'h0, 10'h0);
    bus(1, REG_FLASH, 32'h2);
    bus(1, REG_PROG, 32'h0);
    bus(1, REG_CTRL, 32'h02);
    bus(1, REG_CMD, 32'h1);
    chk_pos(5'h00, 10'h000);
    pump_dot(32'h02, 25'h3);
    chk_pos(5'h00, 10'h001);
    pump_dot(32'h02, 25'h3);
    chk_pos(5'h01, 10'h000);
    pump_dot(32'h02, 25'h6);
    wait_sig("done flash", 2, 1'b1, 60);
    wait_sig("done end", 2, 1'b0, 60);
    pump_dot(32'h02, 25'h3);
    bus(1, REG_CMD, 32'h2);
    chk_pos(5'h01, 10'h000);
    bus(1, REG_CMD, 32'h4);
    chk_pos(5'h00, 10'h000);
    bus(1, REG_CMD, 32'h2);
    chk_pos(5'h00, 10'h001);
    bus(1, REG_CMD, 32'h4);
    bus(1, REG_FLASH, 32'h0);
    pump_dot(32'h02, 25'h6);
    chk("done with zero flash", 32'h0, 32'(prog_done));
    chk_pos(5'h00, 10'h000);
    bus(1, REG_CMD, 32'h4);
    bus(1, REG_PROG, 32'h1);
    bus(0, REG_STATUS, 32'h0);
    chk("step after change", 32'h0, 32'(rd[12:8]));
    bus(1, REG_PROG, 32'h0);
  endtask : t_program

  task automatic t_backflow();
    bus(1, REG_CTRL, 32'h0);
    bus(1, REG_DOT_SIZE, 32'h5);
    bus(1, REG_BF_CNT, 32'h2);
    bus(1, REG_CTRL, 32'h28);
    wait_sig("bf go", 0, 1'b1, 20);
    chk("first size", 32'h5, 32'(move_size));
    bus(1, REG_CTRL, 32'h08);
    wait_sig("reverse", 1, 1'b1, 100);
    chk("reverse size", 32'h2, 32'(move_size));
    wait_sig("bf end", 0, 1'b0, 100);
    repeat (3) @(posedge clock);
    pump_dot(32'h08, 25'h7);
  endtask : t_backflow

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_manual();
    t_line();
    t_auto();
    t_program();
    t_backflow();
    summarize();
  end

  // whole run is a few hundred cycles; this leaves wide margin for a stuck handshake
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
endmodule : pds_sequencer_tb_top
